/* core/iaot_fifo.sv */
// Parameterised FIFO holding converted samples between conversion and output ports.
`timescale 1ns/1ps
module iaot_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} iaot_fifo_state_s;

	iaot_fifo_state_s st;
	iaot_fifo_state_s next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (st.wr_ptr - st.rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = st.wr_ptr != st.rd_ptr;
	assign out_data  = mem[st.rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[st.wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // iaot_fifo

/* core/iaot_pkg.sv */
// Package with constants for the interleaved converter output timing block.
package iaot_pkg;
	localparam int          IAOT_WIDTH       = 8;
	localparam int          IAOT_LATENCY     = 15;
	localparam int          IAOT_FIFO_DEPTH  = 32;
	localparam int          IAOT_TEST_DIV    = 10;
	localparam logic [3:0]  IAOT_TEST_LAST   = 4'h4;
	localparam logic [7:0]  IAOT_MID_CODE    = 8'h80;
	localparam logic [7:0]  IAOT_FULL_CODE   = 8'hff;
	localparam logic [7:0]  IAOT_ZERO_CODE   = 8'h00;
	localparam logic [3:0]  IAOT_CNT_RESET   = 4'h0;
	localparam logic [7:0]  IAOT_DATA_RESET  = 8'h80;
endpackage

/* core/iaot_top.sv */
// Output timing and phasing logic of a two-way interleaved 8-bit converter.
`timescale 1ns/1ps
import iaot_pkg::*;

// Summary of operation
// - Sample clock is halved; the halved phase strobes the two converter halves alternately.
// - Port A result is valid after forwarded clock rise, port B after its fall.
// - Normal mode forwarded clock runs at half the sample clock rate.
// - Strap low gives test mode: divide by ten, fifty percent duty cycle.
// - Test mode keeps the same phasing and keeps one sample of every five.
// - An unconnected strap is pulled low internally by the pad.
// - A toggling tracking input high at the strobe edge selects port A, low selects port B.
// - Each kept sample reaches its port fifteen sample clock cycles after it was taken.
// - Over-range gives all ones and under-range all zeros, never wrapping.
// - Results are offset binary; zero difference gives code 10000000.
// - Each converter half yields an 8-bit word on its own port.
module iaot_top (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [8:0]  sample_signed,
	input  wire logic        output_divide_select,
	input  wire logic        phase_track_input,
	output logic             conv_strobe_a,
	output logic             conv_strobe_b,
	output logic             forwarded_output_clock,
	output logic [7:0]       port_a_result,
	output logic [7:0]       port_b_result,
	output logic             test_mode
);
	//////////////////////////////////////////////////////////////////////////////////////////
	// Registered state of the block.

	typedef struct packed {
		logic [2:0]              strap_sync;
		logic                    strap_lvl;
		logic                    tmode;
		logic                    track_prev;
		logic                    half;
		logic                    last_side;
		logic [3:0]              div_cnt;
		logic                    fclk;
		logic                    stb_a;
		logic                    stb_b;
		logic [7:0]              a_out;
		logic [7:0]              b_out;
		logic [IAOT_LATENCY-1:0] lat_vld;
	} iaot_state_s;

	iaot_state_s st;
	iaot_state_s next_st;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Combinational signals.

	// Coding of the incoming quantizer value.
	logic        over_range;
	logic        under_range;
	logic [7:0]  code;

	// Mode strap and side selection.
	logic        strap_agree;
	logic        strap_new;
	logic        track_toggling;
	logic        next_half;

	// Rate selection and admission of samples.
	logic        div_wrap;
	logic        rate_slot;
	logic        side_fresh;
	logic        keep;
	logic        push_ok;

	// Result FIFO and valid line.
	logic [8:0]  pipe_in;
	logic [8:0]  pipe_out;
	logic        pipe_valid;
	logic        fifo_in_ready;
	logic        drain;
	logic        word_out;
	logic        word_is_b;
	logic        in_flight;

	// Forwarded clock and port loading.
	logic        free_toggle;
	logic        next_fclk;
	logic        load_a;
	logic        load_b;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Offset-binary coding with clamping at both ends of the range.

	// A value above the top code or below the bottom code clamps instead of wrapping.
	assign over_range  = !sample_signed[8] && sample_signed[7];
	assign under_range = sample_signed[8] && !sample_signed[7];

	// Inside the range the sign bit is inverted, so zero difference gives the mid code.
	always_comb begin
		unique case ({over_range, under_range})
			2'b10: begin
				code = IAOT_FULL_CODE;
			end
			2'b01: begin
				code = IAOT_ZERO_CODE;
			end
			default: begin
				code = sample_signed[7:0] ^ IAOT_MID_CODE;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Mode strap and phase tracking.

	// The strap passes three flip-flops; a new level counts once the last two agree.
	assign strap_agree = st.strap_sync[2] == st.strap_sync[1];
	assign strap_new   = strap_agree ? st.strap_sync[1] : st.strap_lvl;

	// Tracking is timed to the sample clock, so it is taken without synchroniser.
	// A toggling input shows that the receiver drives it; its level then picks the side.
	// A held input is not trusted, and the sides simply alternate from the last one.
	assign track_toggling = phase_track_input != st.track_prev;

	always_comb begin
		if (track_toggling) begin
			next_half = !phase_track_input;
		end else begin
			next_half = !st.half;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Sample admission.

	// In test mode the counter runs through five slots and the last one is kept.
	assign div_wrap  = st.div_cnt == 4'(IAOT_TEST_DIV / 2 - 1);
	assign rate_slot = !st.tmode || (st.div_cnt == IAOT_TEST_LAST);

	// A sample is kept only on the other side than the last kept one. Without this a
	// mode change could queue two words of one side, and the second would have no edge.
	assign side_fresh = st.half != st.last_side;
	assign keep       = rate_slot && side_fresh;
	assign push_ok    = keep && fifo_in_ready;
	assign pipe_in    = {st.half, code};

	//////////////////////////////////////////////////////////////////////////////////////////
	// Result FIFO; a word leaves when its slot in the valid line matures.

	assign drain = st.lat_vld[IAOT_LATENCY-1];

	iaot_fifo #(
		.WIDTH(9),
		.DEPTH(IAOT_FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.in_data  (pipe_in),
		.in_valid (keep),
		.in_ready (fifo_in_ready),
		.out_data (pipe_out),
		.out_valid(pipe_valid),
		.out_ready(drain)
	);

	assign word_out  = drain && pipe_valid;
	assign word_is_b = pipe_out[8];
	assign in_flight = |st.lat_vld;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Forwarded clock and port loading.

	// With no word in flight the forwarded clock runs free at the rate of the mode.
	// Once words flow, only they move it, so clock and data can never drift apart.
	assign free_toggle = !in_flight && (!st.tmode || div_wrap);
	assign load_a      = word_out && !word_is_b;
	assign load_b      = word_out && word_is_b;

	// The forwarded clock rises with a side A word and falls with a side B word.
	always_comb begin
		if (word_out) begin
			next_fclk = !word_is_b;
		end else if (free_toggle) begin
			next_fclk = !st.fclk;
		end else begin
			next_fclk = st.fclk;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		next_st = st;

		// Strap low, or left open and pulled low, selects the divide-by-ten test rate.
		next_st.strap_sync = {st.strap_sync[1:0], output_divide_select};
		next_st.strap_lvl  = strap_new;
		next_st.tmode      = !st.strap_lvl;

		// Side selection and the alternating conversion strobes.
		next_st.track_prev = phase_track_input;
		next_st.half       = next_half;
		next_st.stb_a      = !next_half;
		next_st.stb_b      = next_half;

		// Slot counter of the divide-by-ten rate.
		if (st.tmode && !div_wrap) begin
			next_st.div_cnt = st.div_cnt + 4'h1;
		end else begin
			next_st.div_cnt = IAOT_CNT_RESET;
		end

		// Admission and the valid line that sets the latency.
		if (push_ok) begin
			next_st.last_side = st.half;
		end
		next_st.lat_vld = {st.lat_vld[IAOT_LATENCY-2:0], push_ok};

		// Output ports and forwarded clock change in the same cycle.
		next_st.fclk = next_fclk;
		if (load_a) begin
			next_st.a_out = pipe_out[7:0];
		end
		if (load_b) begin
			next_st.b_out = pipe_out[7:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset starts in test mode until the strap has passed its synchroniser.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st.strap_sync <= '0;
			st.strap_lvl  <= 1'b0;
			st.tmode      <= 1'b1;
			st.track_prev <= 1'b0;
			st.half       <= 1'b0;
			st.last_side  <= 1'b1;
			st.div_cnt    <= IAOT_CNT_RESET;
			st.fclk       <= 1'b0;
			st.stb_a      <= 1'b0;
			st.stb_b      <= 1'b0;
			st.a_out      <= IAOT_DATA_RESET;
			st.b_out      <= IAOT_DATA_RESET;
			st.lat_vld    <= '0;
		end else begin
			st <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop.

	// Conversion strobes.
	assign conv_strobe_a          = st.stb_a;
	assign conv_strobe_b          = st.stb_b;

	// Forwarded clock and results.
	assign forwarded_output_clock = st.fclk;
	assign port_a_result          = st.a_out;
	assign port_b_result          = st.b_out;

	// Mode indication.
	assign test_mode              = st.tmode;

endmodule // iaot_top

/* test/iaot_capture.sv */
// Capture logic model registering both ports and driving phase tracking.
`timescale 1ns/1ps
module iaot_capture (
	input  wire logic       sys_clk,
	input  wire logic       forwarded_output_clock,
	input  wire logic [7:0] port_a_result,
	input  wire logic [7:0] port_b_result,
	output logic            phase_track_input,
	output logic      [7:0] cap_a,
	output logic      [7:0] cap_b
);
	logic fq;
	initial phase_track_input = 1'b1;
	always @(negedge sys_clk) phase_track_input <= ~phase_track_input;
	always @(posedge sys_clk) begin
		if (forwarded_output_clock && !fq) cap_a <= port_a_result;
		if (!forwarded_output_clock && fq) cap_b <= port_b_result;
		fq <= forwarded_output_clock;
	end
endmodule // iaot_capture

/* test/iaot_checker.sv */
// Checker of the interleaved output timing block.
`timescale 1ns/1ps
module iaot_checker (
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic [8:0] sample_signed,
	input wire logic       output_divide_select,
	input wire logic       phase_track_input,
	input wire logic       conv_strobe_a,
	input wire logic       conv_strobe_b,
	input wire logic       forwarded_output_clock,
	input wire logic [7:0] port_a_result,
	input wire logic [7:0] port_b_result,
	input wire logic       test_mode
);
	logic [4:0] stab;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) stab <= 5'h00;
		else if ($changed(sample_signed)) stab <= 5'h00;
		else if (stab != 5'h1f) stab <= stab + 5'h01;
	end
	logic [4:0] mode_age;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) mode_age <= 5'h00;
		else if ($changed(test_mode)) mode_age <= 5'h00;
		else if (mode_age != 5'h1f) mode_age <= mode_age + 5'h01;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	AST_STB: assert property ($past(arst_n) |-> conv_strobe_a != conv_strobe_b)
		else $error("strobe overlap");
	AST_NCLK: assert property (mode_age == 5'h1f && !test_mode
		|-> $changed(forwarded_output_clock)) else $error("clock not halved");
	AST_TCLK: assert property (mode_age == 5'h1f && test_mode && $rose(forwarded_output_clock)
		|-> forwarded_output_clock [*5] ##1 !forwarded_output_clock) else $error("duty");
	AST_TMOD: assert property (!output_divide_select [*6] |-> test_mode)
		else $error("no test mode");
	AST_NMOD: assert property (output_divide_select [*6] |-> !test_mode)
		else $error("no normal mode");
	AST_ACH: assert property ($changed(port_a_result)
		|-> $rose(forwarded_output_clock)) else $error("port a edge");
	AST_BCH: assert property ($changed(port_b_result)
		|-> $fell(forwarded_output_clock)) else $error("port b edge");
	AST_PAIR: assert property (stab == 5'h1f |-> port_a_result == port_b_result)
		else $error("ports differ");
	CV_N: cover property (!test_mode && $rose(forwarded_output_clock));
	CV_T: cover property (test_mode && $rose(forwarded_output_clock));
	CV_S: cover property (stab == 5'h1f);
endmodule // iaot_checker
bind iaot_top iaot_checker chk (.*);

/* test/iaot_top_tb.sv */
// Testbench of the interleaved output timing block.
`timescale 1ns/1ps
module iaot_top_tb import iaot_pkg::*;;
	logic       sys_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       strap = 1'b1;
	logic       trk;
	logic       fclk;
	logic       tm;
	logic [8:0] smp = 9'h000;
	logic [7:0] pa, pb, ca, cb;
	logic       sa, sb;
	int         n_mismatch = 0;
	int         n_compared = 0;
	int         n;
	always #5 sys_clk = ~sys_clk;
	iaot_top uut (.sys_clk, .arst_n, .sample_signed(smp), .output_divide_select(strap),
		.phase_track_input(trk), .conv_strobe_a(sa), .conv_strobe_b(sb), .test_mode(tm),
		.forwarded_output_clock(fclk), .port_a_result(pa), .port_b_result(pb));
	iaot_capture cap (.sys_clk, .forwarded_output_clock(fclk), .port_a_result(pa),
		.port_b_result(pb), .phase_track_input(trk), .cap_a(ca), .cap_b(cb));
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task t_code;
		logic [8:0] s [5] = '{9'h000, 9'h07f, 9'h0c8, 9'h138, 9'h180};
		logic [7:0] e [5] = '{8'h80, 8'hff, 8'hff, 8'h00, 8'h00};
		foreach (s[i]) begin
			@(negedge sys_clk) smp = s[i];
			repeat (40) @(negedge sys_clk);
			cmp(ca, e[i]);
			cmp(cb, e[i]);
		end
	endtask
	task t_lat;
		@(negedge sys_clk) smp = 9'h07f;
		n = 0;
		while (pa !== IAOT_FULL_CODE && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		cmp(8'(n > IAOT_LATENCY && n < IAOT_LATENCY + 3), 8'h01);
	endtask
	task t_stb;
		logic a0;
		logic f0;
		@(negedge sys_clk);
		a0 = sa;
		f0 = fclk;
		cmp(8'(sa ^ sb), 8'h01);
		@(negedge sys_clk);
		cmp(8'(sa ^ a0), 8'h01);
		cmp(8'(fclk ^ f0), 8'h01);
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (10) @(negedge sys_clk);
		cmp(8'(tm), 8'h00);
		t_code();
		t_lat();
		t_stb();
		strap = 1'b0;
		repeat (8) @(negedge sys_clk);
		cmp(8'(tm), 8'h01);
		t_code();
		finish_test();
	end
	initial begin
		#20000;
		n_mismatch++;
		finish_test();
	end
endmodule // iaot_top_tb
